//--- rtl/dac_conv_timer.sv
// conversion busy timer
`timescale 1ns/1ps
module dac_conv_timer
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);

    localparam logic [dac_pkg::CONV_CNT_W-1:0] LOAD =
        dac_pkg::CONV_CNT_W'(dac_pkg::CONV_CYCLES - 1);

    logic [dac_pkg::CONV_CNT_W-1:0] count;

    // load on start, count down, busy while running
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            busy  <= 1'b0;
        end
        else if (start)
        begin
            count <= LOAD;
            busy  <= 1'b1;
        end
        else if (count != '0)
            count <= count - 1'b1;
        else
            busy  <= 1'b0;
    end

endmodule

//--- rtl/dac_ctrl.sv
// converter register file, holding registers and update control
`timescale 1ns/1ps
module dac_ctrl
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [dac_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [dac_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [dac_pkg::BE_W-1:0]   avs_byteenable,
    output logic      [dac_pkg::DATA_W-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    input  wire dac_pkg::dac_trig_flags_t   trig_flags,
    output dac_pkg::dac_analog_t            analog_out,
    output logic                            conv_start,
    output logic                            conv_busy
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    dac_pkg::dac_bus_state_t      bus_state;
    logic [7:0]                   control;
    logic [7:0]                   data_high;
    logic [7:0]                   data_low;
    logic                         low_pending;
    logic                         held_left;
    logic                         take;
    logic                         wr_lane0;
    logic                         wr_control;
    logic                         wr_high;
    logic                         wr_low;
    logic                         auto_mode;
    logic                         left_now;
    logic [2:0]                   sel_code;
    logic [dac_pkg::NUM_TRIG-1:0] flag_vec;
    logic [dac_pkg::NUM_TRIG-1:0] rise_vec;
    logic                         sel_rise;
    logic                         trig_take;
    logic                         next_conv_start;
    logic [7:0]                   view_high;
    logic [7:0]                   view_low;
    logic [7:0]                   status;
    logic [dac_pkg::DATA_W-1:0]   next_readdata;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // ten-bit code from the two bytes and an alignment
    function automatic logic [dac_pkg::CODE_W-1:0] dac_join
    (
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic       left
    );
        if (left)
            dac_join = {hi, lo[7:6]};
        else
            dac_join = {hi[1:0], lo};
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************

    // one wait cycle: answer in the cycle after the request shows
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state       <= dac_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            case (bus_state)
                dac_pkg::BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_state       <= dac_pkg::BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                dac_pkg::BUS_ANSWER:
                begin
                    // master releases here; back to waiting
                    bus_state       <= dac_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state       <= dac_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // write strobes, taken at the edge that sees waitrequest low
    assign take       = (bus_state == dac_pkg::BUS_ANSWER);
    assign wr_lane0   = take && avs_write && avs_byteenable[0];
    assign wr_control = wr_lane0 && (avs_address == dac_pkg::ADDR_CONTROL);
    assign wr_high    = wr_lane0 &&
                        (avs_address == dac_pkg::ADDR_DATA_HIGH);
    assign wr_low     = wr_lane0 && (avs_address == dac_pkg::ADDR_DATA_LOW);

    // ****************************************************************
    // control register
    // ****************************************************************

    // reserved bits 3 and 1 never store
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            control <= dac_pkg::CTL_RESET;
        else if (wr_control)
            control <= avs_writedata[7:0] & dac_pkg::CTL_WRITE_MASK;
    end

    // decoded fields
    assign auto_mode = control[dac_pkg::CTL_AUTO_BIT];
    assign left_now  = control[dac_pkg::CTL_LEFT_BIT];
    assign sel_code  = control[dac_pkg::CTL_SEL_HI:dac_pkg::CTL_SEL_LO];

    // ****************************************************************
    // data byte registers
    // ****************************************************************

    // bytes stored as written; alignment is applied on use
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_high <= dac_pkg::DATA_RESET;
            data_low  <= dac_pkg::DATA_RESET;
        end
        else
        begin
            if (wr_high)
                data_high <= avs_writedata[7:0];
            if (wr_low)
                data_low  <= avs_writedata[7:0];
        end
    end

    // low byte written alone arms a block; high byte lifts it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_pending <= 1'b0;
        else if (wr_high)
            low_pending <= 1'b0;
        else if (wr_low)
            low_pending <= 1'b1;
    end

    // alignment frozen at the high byte write, used by triggers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            held_left <= 1'b0;
        else if (wr_high)
            held_left <= left_now;
    end

    // ****************************************************************
    // trigger selection
    // ****************************************************************

    // raw flags, not gated by any interrupt enable
    assign flag_vec = trig_flags;

    // one edge detector per source
    genvar gi;
    generate
        for (gi = 0; gi < dac_pkg::NUM_TRIG; gi = gi + 1)
        begin : g_rise
            dac_rise u_rise
            (
                .clk   (clk),
                .rst_n (rst_n),
                .level (flag_vec[gi]),
                .rise  (rise_vec[gi])
            );
        end
    endgenerate

    // source mux; reserved codes never fire
    always_comb
    begin
        case (sel_code)
            dac_pkg::TRIG_COMP0:    sel_rise = rise_vec[0];
            dac_pkg::TRIG_COMP1:    sel_rise = rise_vec[1];
            dac_pkg::TRIG_EXT_INT0: sel_rise = rise_vec[2];
            dac_pkg::TRIG_T1_OVF:   sel_rise = rise_vec[3];
            dac_pkg::TRIG_T1_CAPT:  sel_rise = rise_vec[4];
            default:                sel_rise = 1'b0;
        endcase
    end

    // edges while busy are dropped, not remembered
    assign trig_take = auto_mode && sel_rise && !conv_busy &&
                       control[dac_pkg::CTL_ENABLE_BIT];

    // ****************************************************************
    // holding registers and analog port
    // ****************************************************************

    // the only path to the core; software never writes it directly
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            analog_out.code <= '0;
        else if (!auto_mode && wr_high)
            analog_out.code <= dac_join(avs_writedata[7:0], data_low,
                                        left_now);
        else if (trig_take && !low_pending)
            analog_out.code <= dac_join(data_high, data_low,
                                        held_left);
    end

    // enable follows the control bit one edge later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            analog_out.enable <= 1'b0;
        else
            analog_out.enable <= control[dac_pkg::CTL_ENABLE_BIT];
    end

    // ****************************************************************
    // conversion start and busy
    // ****************************************************************

    // with the enable bit set, manual mode converts on each high write; auto on a taken edge
    always_comb
    begin
        next_conv_start = 1'b0;
        if (control[dac_pkg::CTL_ENABLE_BIT])
        begin
            if (!auto_mode && wr_high)
                next_conv_start = 1'b1;
            else if (trig_take)
                next_conv_start = 1'b1;
        end
    end

    // registered so the port comes from a flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_start <= 1'b0;
        else
            conv_start <= next_conv_start;
    end

    // busy rises at the same edge as conv_start
    dac_conv_timer u_timer
    (
        .clk   (clk),
        .rst_n (rst_n),
        .start (next_conv_start),
        .busy  (conv_busy)
    );

    // ****************************************************************
    // read path
    // ****************************************************************

    // unused byte positions depend on the current alignment
    always_comb
    begin
        if (left_now)
        begin
            view_high = data_high;
            view_low  = {data_low[7:6], 6'h00};
        end
        else
        begin
            view_high = {6'h00, data_high[1:0]};
            view_low  = data_low;
        end
    end

    // status shows the block's own state
    assign status = {6'h00, low_pending, conv_busy};

    // unmapped addresses read zero
    always_comb
    begin
        next_readdata = '0;
        case (avs_address)
            dac_pkg::ADDR_CONTROL:   next_readdata[7:0] = control;
            dac_pkg::ADDR_DATA_HIGH: next_readdata[7:0] = view_high;
            dac_pkg::ADDR_DATA_LOW:  next_readdata[7:0] = view_low;
            dac_pkg::ADDR_STATUS:    next_readdata[7:0] = status;
            dac_pkg::ADDR_HELD:
                next_readdata[dac_pkg::CODE_W-1:0] = analog_out.code;
            default:                 next_readdata = '0;
        endcase
    end

    // captured as waitrequest drops, stands through the answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= '0;
        else if (bus_state == dac_pkg::BUS_IDLE && avs_read)
            avs_readdata <= next_readdata;
    end

endmodule

//--- rtl/dac_rise.sv
// rising edge detector for one event flag
`timescale 1ns/1ps
module dac_rise
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level,
    output logic      rise
);

    logic prev;

    // previous level; flag is on-chip so no synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev <= 1'b0;
        else
            prev <= level;
    end

    // a level still high gives no new edge
    assign rise = level & ~prev;

endmodule

//--- shared/dac_pkg.sv
// constants and types of the converter register and update block
package dac_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS  = 1000;
    // least time, so round up to whole cycles
    localparam int CONV_CYCLES   =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W    = 4;

    // ****************************************************************
    // bus and register map (byte addresses)
    // ****************************************************************
    localparam int             ADDR_W         = 5;
    localparam int             DATA_W         = 32;
    localparam int             BE_W           = 4;
    localparam logic [4:0]     ADDR_CONTROL   = 5'h00;
    localparam logic [4:0]     ADDR_DATA_HIGH = 5'h04;
    localparam logic [4:0]     ADDR_DATA_LOW  = 5'h08;
    localparam logic [4:0]     ADDR_STATUS    = 5'h0C;
    localparam logic [4:0]     ADDR_HELD      = 5'h10;

    // ****************************************************************
    // control fields and reset values
    // ****************************************************************
    localparam int         CTL_AUTO_BIT   = 7;
    localparam int         CTL_SEL_HI     = 6;
    localparam int         CTL_SEL_LO     = 4;
    localparam int         CTL_LEFT_BIT   = 2;
    localparam int         CTL_ENABLE_BIT = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hF5;
    localparam logic [7:0] CTL_RESET      = 8'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;
    localparam int         STS_BUSY_BIT   = 0;
    localparam int         STS_LOW_BIT    = 1;
    localparam int         CODE_W         = 10;
    localparam int         NUM_TRIG       = 5;

    // trigger source codes; 011, 100, 101 select nothing
    typedef enum logic [2:0] {
        TRIG_COMP0    = 3'h0,
        TRIG_COMP1    = 3'h1,
        TRIG_EXT_INT0 = 3'h2,
        TRIG_T1_OVF   = 3'h6,
        TRIG_T1_CAPT  = 3'h7
    } dac_trig_sel_t;

    // bus answer state
    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } dac_bus_state_t;

    // on-chip event flags, one bit per source
    typedef struct packed {
        logic t1_capt;
        logic t1_ovf;
        logic ext_int0;
        logic comp1;
        logic comp0;
    } dac_trig_flags_t;

    // what the analog core sees
    typedef struct packed {
        logic              enable;
        logic [CODE_W-1:0] code;
    } dac_analog_t;

endpackage

//--- tb/dac_ctrl_assertions.sv
// checker of trigger, conversion and holding-register behaviour
`timescale 1ns/1ps
module dac_ctrl_assertions
(
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic [dac_pkg::ADDR_W-1:0] avs_address,
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic [dac_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [dac_pkg::BE_W-1:0]   avs_byteenable,
    input wire logic [dac_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                       avs_waitrequest,
    input wire dac_pkg::dac_trig_flags_t   trig_flags,
    input wire dac_pkg::dac_analog_t       analog_out,
    input wire logic                       conv_start,
    input wire logic                       conv_busy
);
    // ********************
    // mirrors of the registers
    // ********************
    logic [7:0] ctl;
    logic [7:0] lo;
    logic [4:0] cnt;
    logic       acc;
    logic       hi_wr;
    logic       sel_f;
    logic [9:0] exp_code;
    assign acc      = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign hi_wr    = acc && avs_address == dac_pkg::ADDR_DATA_HIGH;
    assign exp_code = ctl[2] ? {avs_writedata[7:0], lo[7:6]}
                             : {avs_writedata[1:0], lo};
    // selected flag; reserved codes pick nothing
    always_comb
    begin
        case (ctl[6:4])
            3'h0:    sel_f = trig_flags.comp0;
            3'h1:    sel_f = trig_flags.comp1;
            3'h2:    sel_f = trig_flags.ext_int0;
            3'h6:    sel_f = trig_flags.t1_ovf;
            3'h7:    sel_f = trig_flags.t1_capt;
            default: sel_f = 1'b0;
        endcase
    end
    // copy of control and low byte, taken at the answer edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl <= 8'h00;
            lo  <= 8'h00;
        end
        else if (acc && avs_address == dac_pkg::ADDR_CONTROL)
            ctl <= avs_writedata[7:0] & 8'hF5;
        else if (acc && avs_address == dac_pkg::ADDR_DATA_LOW)
            lo <= avs_writedata[7:0];
    end
    // busy length counter, cleared whenever busy is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= 5'h00;
        else
            cnt <= conv_busy ? cnt + 5'h01 : 5'h00;
    end
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_start_edge: assert property (
        ctl[7] && ctl[0] && !conv_busy && sel_f && !$past(sel_f)
        |=> conv_start) else $error("trigger edge did not start");
    chk_start_cause: assert property (
        conv_start && ctl[7] |-> $past(sel_f) && !$past(sel_f, 2))
        else $error("start without a fresh edge");
    chk_start_idle: assert property (
        conv_start |-> conv_busy && !$past(conv_busy))
        else $error("start while busy");
    chk_busy_ends: assert property (
        $fell(conv_busy) |-> cnt == 5'(dac_pkg::CONV_CYCLES) && !conv_start)
        else $error("busy length wrong or start queued");
    chk_start_enabled: assert property (
        conv_start |-> analog_out.enable) else $error("start while off");
    chk_enable_follow: assert property (
        analog_out.enable == $past(ctl[0])) else $error("enable mismatch");
    chk_code_moment: assert property (
        $changed(analog_out.code) |-> conv_start || $past(hi_wr))
        else $error("code changed outside an update");
    chk_code_manual: assert property (
        hi_wr && !ctl[7] |=> analog_out.code == $past(exp_code))
        else $error("manual update code wrong");
    chk_read_upper: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:10] == 22'h0)
        else $error("upper read bits not zero");
    cov_auto_start: cover property (conv_start && ctl[7]);
    cov_held_flag: cover property ($fell(conv_busy) && sel_f);
    cov_left_write: cover property (hi_wr && ctl[2]);
endmodule

bind dac_ctrl dac_ctrl_assertions i_chk
(
    .clk             (clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .trig_flags      (trig_flags),
    .analog_out      (analog_out),
    .conv_start      (conv_start),
    .conv_busy       (conv_busy)
);

//--- tb/dac_ctrl_tb_top.sv
// self-checking bench of the converter register and update block
`timescale 1ns/1ps
module dac_ctrl_tb_top;
    logic                       clk;
    logic                       rst_n;
    logic [dac_pkg::ADDR_W-1:0] avs_address;
    logic                       avs_read;
    logic                       avs_write;
    logic [dac_pkg::DATA_W-1:0] avs_writedata;
    logic [dac_pkg::BE_W-1:0]   avs_byteenable;
    logic [dac_pkg::DATA_W-1:0] avs_readdata;
    logic                       avs_waitrequest;
    dac_pkg::dac_trig_flags_t   trig_flags;
    dac_pkg::dac_analog_t       analog_out;
    logic                       conv_start;
    logic                       conv_busy;
    logic [31:0]                q;
    logic [4:0]                 m;
    logic [7:0]                 v;
    logic [9:0]                 code_exp;
    int                         n_errors;
    int                         samples_checked;
    int                         n_starts;
    int                         base;

    dac_ctrl i_dut
    (
        .clk             (clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .trig_flags      (trig_flags),
        .analog_out      (analog_out),
        .conv_start      (conv_start),
        .conv_busy       (conv_busy)
    );

    // ********************
    // clock, start counter, tasks
    // ********************
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // start pulses stand one cycle, so count them at every edge
    always @(posedge clk)
    begin
        if (conv_start === 1'b1)
            n_starts++;
    end
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
            n_errors++;
        end
    endtask
    // one access, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int i;
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write      <= w;
        avs_read       <= !w;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        if (i == 20)
        begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input string nm, input logic [4:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        check(nm, e, q);
    endtask
    // analog code and its read-only copy must agree with the model
    task automatic code_is(input logic [9:0] e);
        check("code", {22'h0, e}, {22'h0, analog_out.code});
        rd("held", dac_pkg::ADDR_HELD, {22'h0, e});
    endtask
    // flags high for hi cycles, then low for lo cycles
    task automatic flags(input logic [4:0] f, input int hi, input int lo);
        trig_flags <= f;
        repeat (hi) @(posedge clk);
        trig_flags <= 5'h00;
        repeat (lo) @(posedge clk);
    endtask

    // ********************
    // main sequence
    // ********************
    initial
    begin
        n_errors = 0;
        samples_checked = 0;
        n_starts = 0;
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        trig_flags = 5'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd("control", dac_pkg::ADDR_CONTROL, 32'h0);
        rd("high", dac_pkg::ADDR_DATA_HIGH, 32'h0);
        code_is(10'h000);
        rd("unmapped", 5'h14, 32'h0);
        wr(dac_pkg::ADDR_CONTROL, 8'hFF);
        rd("control", dac_pkg::ADDR_CONTROL, 32'hF5);
        bus(1'b1, dac_pkg::ADDR_CONTROL, 8'h00, 4'h0);
        rd("control", dac_pkg::ADDR_CONTROL, 32'hF5);
        wr(dac_pkg::ADDR_CONTROL, 8'h00);
        // manual, right adjusted: a low byte alone changes nothing
        base = n_starts;
        wr(dac_pkg::ADDR_DATA_LOW, 8'hF4);
        code_is(10'h000);
        rd("status", dac_pkg::ADDR_STATUS, 32'h2);
        wr(dac_pkg::ADDR_DATA_HIGH, 8'hFE);
        rd("high", dac_pkg::ADDR_DATA_HIGH, 32'h02);
        code_is(10'h2F4);
        check("starts", base, n_starts);
        // left adjust waits for the next high write
        wr(dac_pkg::ADDR_CONTROL, 8'h05);
        code_is(10'h2F4);
        rd("low", dac_pkg::ADDR_DATA_LOW, 32'hC0);
        check("enable", 32'h1, {31'h0, analog_out.enable});
        wr(dac_pkg::ADDR_DATA_HIGH, 8'hAB);
        code_is(10'h2AF);
        check("starts", base + 1, n_starts);
        // ten cycles of busy, so still running a few accesses later
        rd("status", dac_pkg::ADDR_STATUS, 32'h1);
        code_exp = 10'h2AF;
        // every select code: foreign flags, edge, edge while busy, held
        for (int k = 0; k < 8; k++)
        begin
            m = (k < 3) ? 5'(1 << k) : (k > 5) ? 5'(1 << (k - 3)) : 5'h00;
            v = 8'h30 + 8'(k);
            wr(dac_pkg::ADDR_CONTROL, {1'b1, 3'(k), 4'h5});
            wr(dac_pkg::ADDR_DATA_HIGH, v);
            repeat (12) @(posedge clk);
            base = n_starts;
            flags(~m, 3, 2);
            check("starts", base, n_starts);
            flags(m, 2, 2);
            flags(m, 20, 2);
            check("starts", base + (m != 5'h00), n_starts);
            if (m != 5'h00)
                code_exp = {v, 2'b11};
            code_is(code_exp);
        end
        // a pending low byte blocks the trigger update
        wr(dac_pkg::ADDR_CONTROL, 8'h85);
        wr(dac_pkg::ADDR_DATA_LOW, 8'h40);
        base = n_starts;
        flags(5'h01, 1, 15);
        code_is(code_exp);
        rd("status", dac_pkg::ADDR_STATUS, 32'h2);
        wr(dac_pkg::ADDR_DATA_HIGH, 8'h5A);
        flags(5'h01, 1, 15);
        code_is(10'h169);
        check("starts", base + 2, n_starts);
        rd("status", dac_pkg::ADDR_STATUS, 32'h0);
        wrap_up();
    end
endmodule
